// [core/ffb_cfg.svh]
`ifndef FFB_CFG_SVH
`define FFB_CFG_SVH

// clock and evaluation timing
`define FFB_CLK_HZ          25000000
`define FFB_CYCLE_LIMIT_MS  128
// strictly below the limit, hence the minus one
`define FFB_PERIOD_CYC      ((`FFB_CYCLE_LIMIT_MS * (`FFB_CLK_HZ / 1000)) - 1)

// slot counts
`define FFB_NUM_LOGIC       17
`define FFB_NUM_ARITH       14
`define FFB_NUM_SLOTS       31
`define FFB_NUM_GATES       9
`define FFB_GATES_PER_KIND  3
`define FFB_EXT_W           16
`define FFB_SRC_W           32

// word indices of the register map (byte address = index * 4)
`define FFB_W_CTRL          10'h000
`define FFB_W_STATUS        10'h001
`define FFB_W_COUNT         10'h002
`define FFB_W_LPRIO         10'h010
`define FFB_W_APRIO         10'h030
`define FFB_W_SEL           10'h040

// field positions
`define FFB_CTRL_EN_BIT     0
`define FFB_ST_BUSY_BIT     0
`define FFB_ST_LVL_LSB      1
`define FFB_ST_OUT_LSB      16
`define FFB_SEL_A_LSB       0
`define FFB_SEL_B_LSB       8
`define FFB_SEL_C_LSB       16
`define FFB_SEL_W           5

// reset values
`define FFB_RST_EN          1'b0
`define FFB_RST_PRIO        2'h0
`define FFB_RST_SEL         5'h00

`endif

// [core/ffb_pkg.sv]
package ffb_pkg;
  typedef logic [1:0] ffb_prio_t;
  typedef enum {FFB_IDLE, FFB_SCAN} ffb_state_t;
  typedef enum {FFB_AND, FFB_OR, FFB_XOR} ffb_gate_kind_t;
endpackage : ffb_pkg

// [core/ffb_gate_eval.sv]
`timescale 1ns/1ns
module ffb_gate_eval (
  input  ffb_pkg::ffb_gate_kind_t kind,
  input  wire logic               inA,
  input  wire logic               inB,
  input  wire logic               inC,
  output logic                    result
);
  import ffb_pkg::*;

  // three-input gate over all inputs
  always_comb begin
    case (kind)
      FFB_AND: result = inA & inB & inC;
      FFB_OR:  result = inA | inB | inC;
      FFB_XOR: result = inA ^ inB ^ inC;
      default: result = 1'b0;
    endcase
  end
endmodule : ffb_gate_eval

// [core/ffb_scheduler.sv]
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "ffb_cfg.svh"
module ffb_scheduler #(
  parameter int PERIOD_CYC = `FFB_PERIOD_CYC
) (
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  input  wire logic                    ce,
  input  wire logic [11:0]             addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wrStrobe,
  input  wire logic                    rdStrobe,
  output logic      [31:0]             rdata,
  input  wire logic [`FFB_EXT_W-1:0]   extIn,
  output logic      [`FFB_NUM_GATES-1:0] gateOut,
  output logic                         runStrobe,
  output logic      [4:0]              runSlot,
  output ffb_pkg::ffb_prio_t           runLevel,
  output logic                         evalDone
);
  import ffb_pkg::*;

  localparam int NS = `FFB_NUM_SLOTS;
  localparam int NG = `FFB_NUM_GATES;
  localparam logic [4:0] LAST_SLOT = 5'(NS - 1);

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rstMetaQ;
  logic rstN;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMetaQ <= 1'b0;
      rstN     <= 1'b0;
    end else begin
      rstMetaQ <= 1'b1;
      rstN     <= rstMetaQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register decode
  logic [9:0] wIdx;
  assign wIdx = addr[11:2];

  // true when word index lies in [base, base+n)
  function automatic logic inRange(input logic [9:0] w,
                                   input logic [9:0] base, input int n);
    inRange = (w >= base) && (w < base + 10'(n));
  endfunction : inRange

  // decoded slot priority, arith slots follow logic slots
  function automatic logic [4:0] slotOfWord(input logic [9:0] w);
    logic [9:0] off;
    off = 10'h000;
    if (inRange(w, `FFB_W_LPRIO, `FFB_NUM_LOGIC)) off = w - `FFB_W_LPRIO;
    else off = w - `FFB_W_APRIO + 10'(`FFB_NUM_LOGIC);
    slotOfWord = off[4:0];
  endfunction : slotOfWord

  logic isPrio;
  logic isSel;
  assign isPrio = inRange(wIdx, `FFB_W_LPRIO, `FFB_NUM_LOGIC) ||
                  inRange(wIdx, `FFB_W_APRIO, `FFB_NUM_ARITH);
  assign isSel  = inRange(wIdx, `FFB_W_SEL, NG);

  ////////////////////////////////////////////////////////////////////////
  // software registers
  logic      genEnQ;
  ffb_prio_t prioQ [NS];
  logic [`FFB_SEL_W-1:0] selQ [NG][3];

  // general enable
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) genEnQ <= `FFB_RST_EN;
    else if (ce && wrStrobe && wIdx == `FFB_W_CTRL)
      genEnQ <= wdata[`FFB_CTRL_EN_BIT];
  end

  // one priority entry per slot in both tables
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < NS; i++) prioQ[i] <= `FFB_RST_PRIO;
    end else if (ce && wrStrobe && isPrio) begin
      prioQ[slotOfWord(wIdx)] <= wdata[1:0];
    end
  end

  // input source selects, one word per gate
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      for (int g = 0; g < NG; g++)
        for (int k = 0; k < 3; k++) selQ[g][k] <= `FFB_RST_SEL;
    end else if (ce && wrStrobe && isSel) begin
      selQ[4'(wIdx - `FFB_W_SEL)][0] <= wdata[`FFB_SEL_A_LSB +: 5];
      selQ[4'(wIdx - `FFB_W_SEL)][1] <= wdata[`FFB_SEL_B_LSB +: 5];
      selQ[4'(wIdx - `FFB_W_SEL)][2] <= wdata[`FFB_SEL_C_LSB +: 5];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // evaluation period timer
  logic [31:0] periodCntQ;
  logic        tick;
  assign tick = (periodCntQ == 32'(PERIOD_CYC - 1));

  // free running, so a cycle starts at most once per period, on the tick
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) periodCntQ <= 32'h0000_0000;
    else if (ce) periodCntQ <= tick ? 32'h0000_0000 : periodCntQ + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // scan: level 3 down to 1, slots 0 upward inside each level
  ffb_state_t stateQ;
  ffb_prio_t  levelQ;
  logic [4:0] slotQ;
  logic       hit;
  logic       lastStep;

  assign hit = (stateQ == FFB_SCAN) && genEnQ &&
               (prioQ[slotQ] == levelQ);
  assign lastStep = (slotQ == LAST_SLOT) && (levelQ == 2'h1);

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      stateQ <= FFB_IDLE;
      levelQ <= 2'h3;
      slotQ  <= 5'h00;
    end else if (ce) begin
      case (stateQ)
        FFB_IDLE: begin
          if (tick) begin
            stateQ <= FFB_SCAN;
            levelQ <= 2'h3;
            slotQ  <= 5'h00;
          end
        end
        FFB_SCAN: begin
          if (slotQ == LAST_SLOT) begin
            slotQ  <= 5'h00;
            levelQ <= levelQ - 2'h1;
            if (lastStep) stateQ <= FFB_IDLE;
          end else begin
            slotQ <= slotQ + 5'h01;
          end
        end
        default: stateQ <= FFB_IDLE;
      endcase
    end
  end

  // run report towards the arithmetic and storage units
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      runStrobe <= 1'b0;
      runSlot   <= 5'h00;
      runLevel  <= 2'h0;
      evalDone  <= 1'b0;
    end else if (ce) begin
      runStrobe <= hit;
      runSlot   <= slotQ;
      runLevel  <= levelQ;
      evalDone  <= (stateQ == FFB_SCAN) && lastStep;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // gate slots and source interconnect
  logic [`FFB_SRC_W-1:0] srcBus;
  logic [3:0]            gIdx;
  ffb_gate_kind_t        gKind;
  logic                  gateY;

  // sources 0..15 drive signals, 16..24 gate outputs, rest read zero
  assign srcBus = `FFB_SRC_W'({gateOut, extIn});
  assign gIdx   = (slotQ < 5'(NG)) ? slotQ[3:0] : 4'h0;
  assign gKind  = (gIdx < 4'(`FFB_GATES_PER_KIND)) ? FFB_AND :
                  (gIdx < 4'(2 * `FFB_GATES_PER_KIND)) ? FFB_OR : FFB_XOR;

  ffb_gate_eval u_gate (
    .kind   (gKind),
    .inA    (srcBus[selQ[gIdx][0]]),
    .inB    (srcBus[selQ[gIdx][1]]),
    .inC    (srcBus[selQ[gIdx][2]]),
    .result (gateY)
  );

  // later gates see outputs updated earlier in the same cycle
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) gateOut <= '0;
    else if (ce) begin
      if (!genEnQ) gateOut <= '0;
      else if (hit && slotQ < 5'(NG)) gateOut[gIdx] <= gateY;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cycle counter and read port
  logic [15:0] evalCntQ;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) evalCntQ <= 16'h0000;
    else if (ce && stateQ == FFB_SCAN && lastStep)
      evalCntQ <= evalCntQ + 16'h0001;
  end

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (wIdx == `FFB_W_CTRL) rdMux[`FFB_CTRL_EN_BIT] = genEnQ;
    else if (wIdx == `FFB_W_STATUS) begin
      rdMux[`FFB_ST_BUSY_BIT] = (stateQ == FFB_SCAN);
      rdMux[`FFB_ST_LVL_LSB +: 2] = levelQ;
      rdMux[`FFB_ST_OUT_LSB +: NG] = gateOut;
    end
    else if (wIdx == `FFB_W_COUNT) rdMux[15:0] = evalCntQ;
    else if (isPrio) rdMux[1:0] = prioQ[slotOfWord(wIdx)];
    else if (isSel) begin
      rdMux[`FFB_SEL_A_LSB +: 5] = selQ[4'(wIdx - `FFB_W_SEL)][0];
      rdMux[`FFB_SEL_B_LSB +: 5] = selQ[4'(wIdx - `FFB_W_SEL)][1];
      rdMux[`FFB_SEL_C_LSB +: 5] = selQ[4'(wIdx - `FFB_W_SEL)][2];
    end
  end

  // data only in the cycle after the strobe, zero elsewhere
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) rdata <= 32'h0000_0000;
    else if (ce) rdata <= rdStrobe ? rdMux : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_gen_off;
    @(posedge clock) disable iff (!rstN)
    runStrobe |-> $past(genEnQ);
  endproperty
  a_gen_off: assert property (p_gen_off)
    else $error("block ran while general enable was off");
  property p_entry_match;
    @(posedge clock) disable iff (!rstN)
    (runStrobe && $past(ce)) |-> $past(prioQ[slotQ]) == runLevel;
  endproperty
  a_entry_match: assert property (p_entry_match)
    else $error("run level differs from slot entry");
  property p_level_range;
    @(posedge clock) disable iff (!rstN)
    runStrobe |-> runLevel != 2'h0;
  endproperty
  a_level_range: assert property (p_level_range)
    else $error("inactive slot was run");
  property p_period;
    @(posedge clock) disable iff (!rstN)
    (ce && stateQ == FFB_IDLE && tick) |=> stateQ == FFB_SCAN;
  endproperty
  a_period: assert property (p_period)
    else $error("evaluation cycle did not start on period tick");
  property p_level_order;
    @(posedge clock) disable iff (!rstN)
    (stateQ == FFB_SCAN && $past(stateQ == FFB_SCAN)) |->
      levelQ <= $past(levelQ);
  endproperty
  a_level_order: assert property (p_level_order)
    else $error("scan moved to a higher level");
  property p_and_src;
    @(posedge clock) disable iff (!rstN)
    (runStrobe && runSlot == 5'h00 && $past(ce)) |->
      gateOut[0] == ($past(srcBus[selQ[0][0]]) &
                     $past(srcBus[selQ[0][1]]) &
                     $past(srcBus[selQ[0][2]]));
  endproperty
  a_and_src: assert property (p_and_src)
    else $error("first gate ignored its selected sources");
  property p_or_gate;
    @(posedge clock) disable iff (!rstN)
    (runStrobe && runSlot == 5'h03 && $past(ce)) |->
      gateOut[3] == ($past(srcBus[selQ[3][0]]) |
                     $past(srcBus[selQ[3][1]]) |
                     $past(srcBus[selQ[3][2]]));
  endproperty
  a_or_gate: assert property (p_or_gate)
    else $error("or gate result wrong");
  c_eval_done: cover property (@(posedge clock) disable iff (!rstN)
    evalDone);
  c_top_level: cover property (@(posedge clock) disable iff (!rstN)
    runStrobe && runLevel == 2'h3);
  c_xor_run: cover property (@(posedge clock) disable iff (!rstN)
    runStrobe && runSlot == 5'h06);
  c_arith_run: cover property (@(posedge clock) disable iff (!rstN)
    runStrobe && runSlot > 5'h10);
endmodule : ffb_scheduler

// [verif/tb.sv]
`timescale 1ns/1ns
module tb;
  import ffb_pkg::*;
  localparam int PER = 200;
  logic        clock, rst_b, ce, wrStrobe, rdStrobe, rdPend;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [15:0] extIn;
  logic [8:0]  gateOut, expG;
  logic        runStrobe, evalDone, a, b, c;
  logic [4:0]  runSlot;
  ffb_prio_t   runLevel;
  logic [31:0] rq[$];
  logic [6:0]  sq[$];
  logic [8:0]  gq[$];
  logic [4:0]  src[9][3];
  int          fails, checked, n, seed, dones;
  int          p[31];

  ffb_scheduler #(.PERIOD_CYC(PER)) u_dut (
    .clock(clock), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdata(rdata),
    .extIn(extIn), .gateOut(gateOut), .runStrobe(runStrobe),
    .runSlot(runSlot), .runLevel(runLevel), .evalDone(evalDone));

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task end_sim;
    if (rq.size() + sq.size() + gq.size() != 0) fails++;
    $display("counts: %0d compared, %0d wrong", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  // each task sets both strobes, so back to back calls never clash
  task wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clock);
    addr     <= ad;
    wdata    <= d;
    wrStrobe <= 1'b1;
    rdStrobe <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] ad, input logic [31:0] e);
    @(posedge clock);
    rq.push_back(e);
    addr     <= ad;
    rdStrobe <= 1'b1;
    wrStrobe <= 1'b0;
  endtask : rd

  task idle;
    @(posedge clock);
    wrStrobe <= 1'b0;
    rdStrobe <= 1'b0;
  endtask : idle

  function automatic logic [11:0] pa(input int s);
    return (s < 17) ? 12'(12'h040 + 4 * s) : 12'(12'h0C0 + 4 * (s - 17));
  endfunction : pa

  // bounded wait for the end-of-cycle pulse
  task waitDone(output int k);
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (evalDone !== 1'b1 && k < 400);
    if (evalDone !== 1'b1) begin
      fails++;
      end_sim();
    end else begin
      dones++;
    end
  endtask : waitDone

  // sync to a cycle end, load priorities, note the expected run order;
  // entries are cleared afterwards, so the next sync scan runs nothing
  task sched(input bit per, input bit gt);
    waitDone(n);
    for (int s = 0; s < 31; s++) wr(pa(s), 32'(p[s]));
    for (int lv = 3; lv > 0; lv--)
      for (int s = 0; s < 31; s++)
        if (p[s] == lv) sq.push_back({5'(s), 2'(lv)});
    if (gt) gq.push_back(expG);
    idle;
    waitDone(n);
    for (int s = 0; s < 31; s++)
      if (p[s] != 0) wr(pa(s), 0);
    idle;
    // two cycle ends back to back give one full period
    if (per) begin
      waitDone(n);
      waitDone(n);
      chk(32'(n), 32'(PER));
    end
  endtask : sched

  //////////////////////////////////////////////////////////////////////////
  // monitor: each result that appears takes the oldest expectation
  always @(posedge clock) begin
    if (rdPend) chk(rdata, rq.pop_front());
    rdPend <= rdStrobe;
    if (runStrobe === 1'b1) begin
      if (sq.size() == 0) chk(32'({runSlot, runLevel}), 32'hFFFF_FFFF);
      else chk(32'({runSlot, runLevel}), 32'(sq.pop_front()));
    end
    if (evalDone === 1'b1 && gq.size() != 0)
      chk(32'(gateOut), 32'(gq.pop_front()));
  end

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    ce = 1'b1;
    rst_b = 1'b0;
    addr = '0;
    wdata = '0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    extIn = '0;
    rdPend = 1'b0;
    seed = $urandom(32'h69f9);
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    // reset values, read back, upper bits dropped, unmapped place
    rd(12'h000, 0);
    rd(pa(0), 0);
    rd(pa(30), 0);
    wr(12'h000, 32'hFFFF_FFFF);
    rd(12'h000, 1);
    // a write while the clock enable is low must be ignored
    idle;
    ce <= 1'b0;
    wr(12'h000, 0);
    idle;
    ce <= 1'b1;
    rd(12'h000, 1);
    wr(pa(30), 32'hFFFF_FFFF);
    rd(pa(30), 3);
    wr(pa(30), 0);
    wr(12'h3FC, 32'hFFFF_FFFF);
    rd(12'h3FC, 0);
    idle;
    $display("test registers done");
    // gates over random drive signals; gate 8 also takes gate 0's output
    extIn <= 16'($urandom);
    for (int g = 0; g < 9; g++) begin
      for (int i = 0; i < 3; i++) src[g][i] = 5'($urandom_range(15));
      if (g == 8) src[g][2] = 5'h10;
      wr(12'(12'h100 + 4 * g),
         {11'h000, src[g][2], 3'h0, src[g][1], 3'h0, src[g][0]});
    end
    idle;
    for (int g = 0; g < 9; g++) begin
      a = extIn[src[g][0][3:0]];
      b = extIn[src[g][1][3:0]];
      c = (g == 8) ? expG[0] : extIn[src[g][2][3:0]];
      expG[g] = (g < 3) ? (a & b & c) : (g < 6) ? (a | b | c) : (a ^ b ^ c);
    end
    for (int s = 0; s < 31; s++) p[s] = (s < 9) ? 3 : 0;
    sched(0, 1);
    sched(1, 1);
    rd(12'h004, 32'(expG) << 16);
    idle;
    $display("test gates done");
    // three levels in the logic table, two in the arith table, mixed
    for (int s = 0; s < 31; s++) p[s] = 0;
    p[0] = 1;
    p[1] = 2;
    p[2] = 3;
    p[29] = 2;
    p[30] = 3;
    sched(0, 0);
    for (int s = 0; s < 31; s++) p[s] = $urandom_range(3);
    sched(0, 0);
    $display("test order done");
    // general enable off: no slot may run and gate outputs clear
    waitDone(n);
    rd(12'h008, 32'(dones));
    wr(12'h000, 0);
    for (int s = 0; s < 31; s++) wr(pa(s), 3);
    gq.push_back(9'h000);
    rd(12'h000, 0);
    idle;
    waitDone(n);
    rd(12'h004, 0);
    repeat (3) idle;
    $display("test disable done");
    end_sim();
  end
endmodule : tb
